// [rtl/acxu_pkg.sv]
// acxu_pkg: constants and types of the accumulator extract unit
// assumes one core clock shared by the pipeline and the register bus
package acxu_pkg;

	// instruction word layout
	localparam logic [5:0] ACXU_OPC_MAJOR = 6'h00;
	localparam logic [5:0] ACXU_OPC_MINOR = 6'h3c;
	localparam int ACXU_MAJ_HI = 31;
	localparam int ACXU_MAJ_LO = 26;
	localparam int ACXU_DST_HI = 25;
	localparam int ACXU_DST_LO = 21;
	localparam int ACXU_SRC_HI = 20;
	localparam int ACXU_SRC_LO = 16;
	localparam int ACXU_ACC_HI = 15;
	localparam int ACXU_ACC_LO = 14;
	localparam int ACXU_SUB_HI = 13;
	localparam int ACXU_SUB_LO = 6;
	localparam int ACXU_MIN_HI = 5;

	// sub-opcodes
	localparam logic [7:0] ACXU_SUB_POS = 8'ha2;
	localparam logic [7:0] ACXU_SUB_WTRUNC = 8'h39;
	localparam logic [7:0] ACXU_SUB_WROUND = 8'h79;
	localparam logic [7:0] ACXU_SUB_WRSAT = 8'hb9;
	localparam logic [7:0] ACXU_SUB_HVAR = 8'hfa;
	localparam logic [7:0] ACXU_SUB_HIMM = 8'hf9;

	// control register fields
	localparam int ACXU_CTRL_POS_HI = 5;
	localparam int ACXU_CTRL_XFAIL = 14;
	localparam int ACXU_CTRL_OUF = 23;
	localparam logic [31:0] ACXU_CTRL_RST = 32'h00000000;

	// saturation limits
	localparam logic [63:0] ACXU_HALF_MAX = 64'h0000000000007fff;
	localparam logic [63:0] ACXU_HALF_MIN = 64'hffffffffffff8000;
	localparam logic [31:0] ACXU_HALF_MAX_OUT = 32'h00007fff;
	localparam logic [31:0] ACXU_HALF_MIN_OUT = 32'hffff8000;
	localparam logic [31:0] ACXU_WORD_MAX = 32'h7fffffff;
	localparam logic [31:0] ACXU_WORD_MIN = 32'h80000000;
	localparam logic [32:0] ACXU_WORD_ONES = 33'h1ffffffff;
	localparam logic [31:0] ACXU_FIELD_ONES = 32'hffffffff;

	// register map, byte addresses
	localparam int ACXU_AW = 6;
	localparam logic [5:0] ACXU_ADDR_CTRL = 6'h00;
	localparam logic [5:0] ACXU_ADDR_ISTAT = 6'h04;
	localparam logic [5:0] ACXU_ADDR_IMASK = 6'h08;
	localparam logic [5:0] ACXU_ADDR_RESULT = 6'h0c;
	localparam logic [5:0] ACXU_ADDR_ACC_LO = 6'h10;
	localparam logic [5:0] ACXU_ADDR_ACC_HI = 6'h2c;

	// interrupt status bits
	localparam int ACXU_IRQ_W = 2;
	localparam int ACXU_IRQ_FAIL = 0;
	localparam int ACXU_IRQ_OUF = 1;
	localparam logic [1:0] ACXU_IRQ_RST = 2'h0;

	typedef enum logic [2:0] {
		ACXU_OP_NONE,
		ACXU_OP_POS,
		ACXU_OP_HIMM,
		ACXU_OP_HVAR,
		ACXU_OP_WTRUNC,
		ACXU_OP_WROUND,
		ACXU_OP_WRSAT
	} acxu_op_t;

	typedef struct packed {
		logic [31:0] instr;
		logic [31:0] src;
	} acxu_issue_t;

	typedef struct packed {
		logic [4:0] dest;
		logic [31:0] data;
	} acxu_wb_t;

endpackage

// [rtl/acxu_core.sv]
// acxu_core: extracts fields and shifted words from four 64-bit accumulators
// assumes the pipeline and the Avalon-MM master share i_clock
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module acxu_core
	import acxu_pkg::*;
(
	// clock, reset, enable
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_ce,
	// pipeline issue
	input wire logic i_issue_valid,
	input wire acxu_issue_t i_issue,
	output logic o_issue_ready,
	// pipeline writeback
	output logic o_wb_valid,
	output acxu_wb_t o_wb,
	output logic [31:0] o_dsp_control,
	// avalon-mm slave
	input wire logic [ACXU_AW-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// interrupt
	output logic o_irq
);

	logic [63:0] acc_reg [0:3];
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	logic [ACXU_IRQ_W-1:0] istat_reg;
	logic [ACXU_IRQ_W-1:0] istat_next;
	logic [ACXU_IRQ_W-1:0] imask_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic wb_valid_reg;
	acxu_wb_t wb_reg;
	acxu_wb_t wb_next;
	acxu_op_t op;
	acxu_op_t op_reg;

	logic issue_fire;
	logic bus_req;
	logic bus_wr;
	logic sw_ctrl_wr;
	logic [5:0] acc_off;
	logic acc_hit;
	logic [1:0] acc_sel;
	logic [63:0] acc;
	logic [4:0] shamt;
	logic [4:0] size;
	logic [5:0] start_pos;
	logic pos_ok;
	logic [5:0] pos_lsb;
	logic [63:0] pos_shifted;
	logic [31:0] pos_data;
	logic [63:0] hs;
	logic sat_hi;
	logic sat_lo;
	logic sign_flag;
	logic [64:0] wt;
	logic [64:0] wr;
	logic ov_pre;
	logic ov_post;
	logic op_ovf;

	// decode
	always_comb begin
		op = ACXU_OP_NONE;
		if (i_issue.instr[ACXU_MAJ_HI:ACXU_MAJ_LO] == ACXU_OPC_MAJOR &&
		    i_issue.instr[ACXU_MIN_HI:0] == ACXU_OPC_MINOR) begin
			case (i_issue.instr[ACXU_SUB_HI:ACXU_SUB_LO])
				ACXU_SUB_POS: op = ACXU_OP_POS;
				ACXU_SUB_HIMM: op = ACXU_OP_HIMM;
				ACXU_SUB_HVAR: op = ACXU_OP_HVAR;
				ACXU_SUB_WTRUNC: op = ACXU_OP_WTRUNC;
				ACXU_SUB_WROUND: op = ACXU_OP_WROUND;
				ACXU_SUB_WRSAT: op = ACXU_OP_WRSAT;
				default: op = ACXU_OP_NONE;
			endcase
		end
	end

	// single-cycle datapath, so the pipeline is only held by the enable
	assign o_issue_ready = i_ce;
	assign issue_fire = i_issue_valid && i_ce && op != ACXU_OP_NONE;

	assign acc_sel = i_issue.instr[ACXU_ACC_HI:ACXU_ACC_LO];
	assign acc = acc_reg[acc_sel];

	// variable forms take only the low five source bits
	assign shamt = (op == ACXU_OP_HVAR) ? i_issue.src[4:0] :
		i_issue.instr[ACXU_SRC_LO+4:ACXU_SRC_LO];
	assign size = i_issue.src[4:0];

	// positional extract
	assign start_pos = ctrl_reg[ACXU_CTRL_POS_HI:0];
	assign pos_ok = start_pos >= {1'b0, size};
	assign pos_lsb = start_pos - {1'b0, size};
	assign pos_shifted = acc >> pos_lsb;
	assign pos_data = pos_shifted[31:0] &
		(ACXU_FIELD_ONES >> (5'd31 - size));

	// halfword path
	assign hs = $signed(acc) >>> shamt;
	assign sign_flag = acc[63] != hs[31];
	assign sat_hi = $signed(hs) > $signed(ACXU_HALF_MAX);
	assign sat_lo = $signed(hs) < $signed(ACXU_HALF_MIN);

	// word path: a zero shift leaves a zero guard bit below the accumulator
	assign wt = $signed({acc, 1'b0}) >>> shamt;
	assign wr = wt + 65'h1;
	assign ov_pre = wt[64:32] != 33'h0 && wt[64:32] != ACXU_WORD_ONES;
	assign ov_post = wr[64:32] != 33'h0 && wr[64:32] != ACXU_WORD_ONES;

	always_comb begin
		wb_next.dest = i_issue.instr[ACXU_DST_HI:ACXU_DST_LO];
		wb_next.data = 32'h0;
		op_ovf = 1'b0;
		case (op)
			ACXU_OP_POS: begin
				// failed extract is unpredictable, zero is returned
				wb_next.data = pos_ok ? pos_data : 32'h0;
			end
			ACXU_OP_HIMM, ACXU_OP_HVAR: begin
				if (sat_hi)
					wb_next.data = ACXU_HALF_MAX_OUT;
				else if (sat_lo)
					wb_next.data = ACXU_HALF_MIN_OUT;
				else
					wb_next.data = hs[31:0];
				op_ovf = sat_hi || sat_lo || sign_flag;
			end
			ACXU_OP_WTRUNC: begin
				wb_next.data = wt[32:1];
				op_ovf = ov_pre || ov_post;
			end
			ACXU_OP_WROUND: begin
				wb_next.data = wr[32:1];
				op_ovf = ov_pre || ov_post;
			end
			ACXU_OP_WRSAT: begin
				if (ov_post)
					wb_next.data = wr[64] ? ACXU_WORD_MIN : ACXU_WORD_MAX;
				else
					wb_next.data = wr[32:1];
				op_ovf = ov_pre || ov_post;
			end
			default: begin
				wb_next.data = 32'h0;
			end
		endcase
	end

	// bus decode
	assign bus_req = i_avs_read || i_avs_write;
	assign bus_wr = i_avs_write && ack_reg;
	// a frozen enable must not accept, or the write would be lost
	assign o_avs_waitrequest = bus_req && !(ack_reg && i_ce);
	assign sw_ctrl_wr = bus_wr && i_avs_address == ACXU_ADDR_CTRL;
	assign acc_off = i_avs_address - ACXU_ADDR_ACC_LO;
	assign acc_hit = i_avs_address >= ACXU_ADDR_ACC_LO &&
		i_avs_address <= ACXU_ADDR_ACC_HI && i_avs_address[1:0] == 2'h0;

	// control register: a hardware flag set beats a software clear
	always_comb begin
		ctrl_next = ctrl_reg;
		if (sw_ctrl_wr)
			ctrl_next = i_avs_writedata;
		if (issue_fire) begin
			if (op == ACXU_OP_POS)
				ctrl_next[ACXU_CTRL_XFAIL] = !pos_ok;
			if (op_ovf)
				ctrl_next[ACXU_CTRL_OUF] = 1'b1;
		end
	end

	always_comb begin
		istat_next = istat_reg;
		if (bus_wr && i_avs_address == ACXU_ADDR_ISTAT)
			istat_next = istat_reg & ~i_avs_writedata[ACXU_IRQ_W-1:0];
		if (issue_fire && op == ACXU_OP_POS && !pos_ok)
			istat_next[ACXU_IRQ_FAIL] = 1'b1;
		if (issue_fire && op_ovf)
			istat_next[ACXU_IRQ_OUF] = 1'b1;
	end

	always_comb begin
		rdata_next = 32'h0;
		if (i_avs_address == ACXU_ADDR_CTRL)
			rdata_next = ctrl_reg;
		else if (i_avs_address == ACXU_ADDR_ISTAT)
			rdata_next = {30'h0, istat_reg};
		else if (i_avs_address == ACXU_ADDR_IMASK)
			rdata_next = {30'h0, imask_reg};
		else if (i_avs_address == ACXU_ADDR_RESULT)
			rdata_next = wb_reg.data;
		else if (acc_hit)
			rdata_next = acc_off[2] ? acc_reg[acc_off[4:3]][31:0] :
				acc_reg[acc_off[4:3]][63:32];
	end

	// one wait state per access
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0;
		end else if (i_ce) begin
			ack_reg <= bus_req && !ack_reg;
			if (bus_req && !ack_reg)
				rdata_reg <= rdata_next;
		end
	end

	// only the bus writes accumulators; extracts just read them
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int i = 0; i < 4; i++)
				acc_reg[i] <= 64'h0;
		end else if (i_ce && bus_wr && acc_hit) begin
			if (acc_off[2])
				acc_reg[acc_off[4:3]][31:0] <= i_avs_writedata;
			else
				acc_reg[acc_off[4:3]][63:32] <= i_avs_writedata;
		end
	end

	// result and flags land on the same edge
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl_reg <= ACXU_CTRL_RST;
			wb_valid_reg <= 1'b0;
			wb_reg <= '0;
			op_reg <= ACXU_OP_NONE;
		end else if (i_ce) begin
			ctrl_reg <= ctrl_next;
			wb_valid_reg <= issue_fire;
			if (issue_fire) begin
				wb_reg <= wb_next;
				op_reg <= op;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			istat_reg <= ACXU_IRQ_RST;
			imask_reg <= ACXU_IRQ_RST;
		end else if (i_ce) begin
			istat_reg <= istat_next;
			if (bus_wr && i_avs_address == ACXU_ADDR_IMASK)
				imask_reg <= i_avs_writedata[ACXU_IRQ_W-1:0];
		end
	end

	assign o_avs_readdata = rdata_reg;
	assign o_wb_valid = wb_valid_reg;
	assign o_wb = wb_reg;
	assign o_dsp_control = ctrl_reg;
	assign o_irq = |(istat_reg & imask_reg);

	// checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);

	sequence s_pos_issue;
		issue_fire && op == ACXU_OP_POS;
	endsequence

	sequence s_half_issue;
		issue_fire && (op == ACXU_OP_HIMM || op == ACXU_OP_HVAR);
	endsequence

	sequence s_word_issue;
		issue_fire && (op == ACXU_OP_WTRUNC || op == ACXU_OP_WROUND ||
			op == ACXU_OP_WRSAT);
	endsequence

	a_pos_fail_flag: assert property (
		s_pos_issue ##0 (ctrl_reg[5:0] < {1'b0, i_issue.src[4:0]})
		|=> ctrl_reg[ACXU_CTRL_XFAIL] && o_wb_valid)
		else $error("extract fail flag not set");

	a_pos_zero_ext: assert property (
		s_pos_issue ##0 (ctrl_reg[5:0] >= {1'b0, i_issue.src[4:0]})
		|=> !ctrl_reg[ACXU_CTRL_XFAIL] &&
		(o_wb.data >> ($past(i_issue.src[4:0]) + 6'd1)) == 32'h0)
		else $error("positional extract not zero extended");

	a_pos_keep_field: assert property (
		s_pos_issue ##0 !sw_ctrl_wr
		|=> ctrl_reg[5:0] == $past(ctrl_reg[5:0]))
		else $error("position field changed by extract");

	a_half_clamp_hi: assert property (
		s_half_issue ##0 ($signed(acc) >>> shamt > 64'sh7fff)
		|=> o_wb.data == 32'h00007fff && ctrl_reg[ACXU_CTRL_OUF])
		else $error("halfword upper clamp wrong");

	a_half_sign_ext: assert property (
		o_wb_valid && (op_reg == ACXU_OP_HIMM || op_reg == ACXU_OP_HVAR)
		|-> o_wb.data[31:15] == 17'h0 || o_wb.data[31:15] == 17'h1ffff)
		else $error("halfword result not sign extended");

	a_ovf_sticky: assert property (
		ctrl_reg[ACXU_CTRL_OUF] && !(i_ce && sw_ctrl_wr)
		|=> ctrl_reg[ACXU_CTRL_OUF])
		else $error("overflow flag dropped");

	a_acc_unchanged: assert property (
		issue_fire && !bus_wr |=> acc_reg[$past(acc_sel)] == $past(acc))
		else $error("extract modified accumulator");

	a_word_ovf_flag: assert property (
		s_word_issue ##0 (ov_pre || ov_post)
		|=> ctrl_reg[ACXU_CTRL_OUF] ##0 $rose(o_wb_valid) or
		ctrl_reg[ACXU_CTRL_OUF] ##0 o_wb_valid)
		else $error("word overflow flag not set");

	a_round_sat_clamp: assert property (
		issue_fire && op == ACXU_OP_WRSAT && ov_post
		|=> o_wb.data == ($past(wr[64]) ? 32'h80000000 : 32'h7fffffff))
		else $error("round saturate clamp wrong");

	a_word_trunc: assert property (
		issue_fire && op == ACXU_OP_WTRUNC
		|=> o_wb.data == $past(acc[31:0]) ||
		$past(shamt) != 5'h0)
		else $error("zero shift truncation wrong");

	a_unknown_quiet: assert property (
		i_issue_valid && i_ce && op == ACXU_OP_NONE |=> !o_wb_valid)
		else $error("unknown opcode produced writeback");

	a_half_clamp_lo: assert property (
		s_half_issue ##0 ($signed(acc) >>> shamt < 64'shffffffffffff8000)
		|=> o_wb.data == 32'hffff8000 && ctrl_reg[ACXU_CTRL_OUF])
		else $error("halfword lower clamp wrong");

	a_shift_sign_flag: assert property (
		s_half_issue ##0 (acc[63] != hs[31])
		|=> ctrl_reg[ACXU_CTRL_OUF])
		else $error("shift sign mismatch not flagged");

	a_round_guard: assert property (
		issue_fire && op == ACXU_OP_WROUND
		|=> o_wb.data == $past(wt[32:1]) + 32'($past(wt[0])))
		else $error("rounding not added at guard bit");

	a_wb_together: assert property (
		issue_fire |=> o_wb_valid &&
		o_wb.dest == $past(i_issue.instr[ACXU_DST_HI:ACXU_DST_LO]))
		else $error("writeback not paired with its issue");

	a_ce_freeze: assert property (
		!i_ce |=> $stable(ctrl_reg) && $stable(istat_reg) && $stable(wb_reg))
		else $error("state changed with enable low");

endmodule // acxu_core

`default_nettype wire

// [sim/acxu_pipe_model.sv]
// acxu_pipe_model: issue side of the pipeline, one extract at a time
// assumes a word is taken at the edge that sees ready high
`timescale 1ns/1ps
`default_nettype none

module acxu_pipe_model
	import acxu_pkg::*;
(
	// clock
	input wire logic i_clock,
	// issue
	output logic o_valid,
	output acxu_issue_t o_issue,
	input wire logic i_ready,
	// writeback
	input wire logic i_wb_valid,
	input wire acxu_wb_t i_wb,
	input wire logic [31:0] i_ctrl
);
	initial begin
		o_valid = 1'b0;
		o_issue = '0;
	end

	// offer one word, then look at the cycle after its taking edge
	task automatic run(input logic [31:0] ins, input logic [31:0] src,
			output logic got, output acxu_wb_t wb, output logic [31:0] ctl);
		int n;
		n = 0;
		@(posedge i_clock);
		o_valid <= 1'b1;
		o_issue <= {ins, src};
		// held until the edge that sees ready high; bounded wait
		do begin
			@(posedge i_clock);
			n++;
		end while (i_ready !== 1'b1 && n < 50);
		o_valid <= 1'b0;
		// released lines flip so a stale word never passes for a held one
		o_issue <= ~{ins, src};
		@(posedge i_clock);
		got = i_wb_valid;
		wb = i_wb;
		ctl = i_ctrl;
	endtask
endmodule // acxu_pipe_model

`default_nettype wire

// [sim/tb_top.sv]
// tb_top: self-checking bench of the accumulator extract unit
// assumes one core clock; registers reached over avalon-mm
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import acxu_pkg::*;
;
	typedef struct packed {
		logic [7:0] sub;
		logic [1:0] sel;
		logic [4:0] sh;
		logic [31:0] src, cin, dat, cex;
		logic chk;
	} acxu_row_t;

	logic clock, rst_b, issue_valid, wb_valid, irq;
	logic avs_read, avs_write, avs_wait, got, ce, issue_ready;
	acxu_issue_t issue;
	acxu_wb_t wb_out, wb;
	logic [31:0] dsp_control, avs_wdata, avs_rdata, q, ctl;
	logic [5:0] avs_addr;
	acxu_row_t r;
	int num_errors, cmp_count;
	logic [63:0] acc [4] = '{64'h12345678, 64'hffffffffffff0000,
		64'h8000000000000000, 64'hffffffff};
	// failing positional row has no data check: its value is undefined
	acxu_row_t rows [17] = '{
		{8'hf9, 2'd0, 5'd0, 32'h0, 32'h0, 32'h7fff, 32'h800000, 1'b1},
		{8'hf9, 2'd1, 5'd4, 32'h0, 32'h800000, 32'hfffff000, 32'h800000, 1'b1},
		{8'hfa, 2'd1, 5'd0, 32'hffffffe0, 32'h0, 32'hffff8000, 32'h800000, 1'b1},
		{8'hfa, 2'd0, 5'd0, 32'h10, 32'h0, 32'h1234, 32'h0, 1'b1},
		{8'hf9, 2'd2, 5'd31, 32'h0, 32'h0, 32'hffff8000, 32'h800000, 1'b1},
		{8'h39, 2'd0, 5'd0, 32'h0, 32'h0, 32'h12345678, 32'h0, 1'b1},
		{8'h39, 2'd3, 5'd0, 32'h0, 32'h0, 32'hffffffff, 32'h800000, 1'b1},
		{8'h39, 2'd3, 5'd1, 32'h0, 32'h0, 32'h7fffffff, 32'h800000, 1'b1},
		{8'h79, 2'd0, 5'd4, 32'h0, 32'h0, 32'h1234568, 32'h0, 1'b1},
		{8'h79, 2'd3, 5'd1, 32'h0, 32'h0, 32'h80000000, 32'h800000, 1'b1},
		{8'hb9, 2'd3, 5'd1, 32'h0, 32'h0, 32'h7fffffff, 32'h800000, 1'b1},
		{8'hb9, 2'd2, 5'd0, 32'h0, 32'h0, 32'h80000000, 32'h800000, 1'b1},
		{8'hb9, 2'd1, 5'd31, 32'h0, 32'h0, 32'h0, 32'h0, 1'b1},
		{8'ha2, 2'd0, 5'd0, 32'hffffffe7, 32'h1f, 32'h12, 32'h1f, 1'b1},
		{8'ha2, 2'd2, 5'd0, 32'h0, 32'h3f, 32'h1, 32'h3f, 1'b1},
		{8'ha2, 2'd1, 5'd0, 32'h5, 32'h4, 32'h0, 32'h4004, 1'b0},
		{8'ha2, 2'd0, 5'd0, 32'h4, 32'h4004, 32'h18, 32'h4, 1'b1}};

	acxu_core dut (
		.i_clock(clock), .i_rst_b(rst_b), .i_ce(ce),
		.i_issue_valid(issue_valid), .i_issue(issue),
		.o_issue_ready(issue_ready),
		.o_wb_valid(wb_valid), .o_wb(wb_out), .o_dsp_control(dsp_control),
		.i_avs_address(avs_addr), .i_avs_read(avs_read),
		.i_avs_write(avs_write), .i_avs_writedata(avs_wdata),
		.o_avs_readdata(avs_rdata), .o_avs_waitrequest(avs_wait),
		.o_irq(irq)
	);

	acxu_pipe_model pipe (
		.i_clock(clock), .o_valid(issue_valid), .o_issue(issue),
		.i_ready(issue_ready),
		.i_wb_valid(wb_valid), .i_wb(wb_out), .i_ctrl(dsp_control)
	);

	always #10 clock = ~clock;

	task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
		cmp_count++;
		if (got_v !== exp_v) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got_v, exp_v);
		end
	endtask

	// held until waitrequest is seen low; a stuck slave ends the wait
	task automatic bus(input logic wr, input logic [5:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		avs_read <= !wr;
		avs_write <= wr;
		avs_addr <= a;
		avs_wdata <= d;
		do begin
			@(posedge clock);
			n++;
		end while (avs_wait !== 1'b0 && n < 20);
		q = avs_rdata;
		if (n >= 20)
			chk(32'h1, 32'h0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic stop_test();
		if (num_errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		stop_test();
	end

	initial begin
		clock = 1'b0;
		rst_b = 1'b0;
		ce = 1'b1;
		{avs_read, avs_write, avs_addr, avs_wdata} = '0;
		num_errors = 0;
		cmp_count = 0;
		repeat (20) @(posedge clock);
		chk(dsp_control, ACXU_CTRL_RST);
		chk({30'h0, irq, wb_valid}, 32'h0);
		rst_b <= 1'b1;
		for (int a = 0; a < 12; a += 4) begin
			bus(1'b0, 6'(a), 32'h0);
			chk(q, 32'h0);
		end
		for (int n = 0; n < 4; n++) begin
			bus(1'b1, 6'(16 + 8 * n), acc[n][63:32]);
			bus(1'b1, 6'(20 + 8 * n), acc[n][31:0]);
		end
		foreach (rows[i]) begin
			r = rows[i];
			bus(1'b1, ACXU_ADDR_CTRL, r.cin);
			pipe.run({6'h00, 5'(i), r.sh, r.sel, r.sub, 6'h3c}, r.src,
				got, wb, ctl);
			chk({31'h0, got}, 32'h1);
			chk({27'h0, wb.dest}, 32'(i));
			if (r.chk)
				chk(wb.data, r.dat);
			chk(ctl, r.cex);
		end
		// accumulators must survive every extract
		for (int n = 0; n < 4; n++) begin
			bus(1'b0, 6'(16 + 8 * n), 32'h0);
			chk(q, acc[n][63:32]);
			bus(1'b0, 6'(20 + 8 * n), 32'h0);
			chk(q, acc[n][31:0]);
		end
		bus(1'b1, ACXU_ADDR_RESULT, 32'hdead);
		bus(1'b0, ACXU_ADDR_RESULT, 32'h0);
		chk(q, 32'h18);
		bus(1'b1, 6'h3c, 32'hffffffff);
		bus(1'b0, 6'h3c, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, 6'h02, 32'h0);
		chk(q, 32'h0);
		// wrong major, wrong minor, unknown sub-opcode
		bus(1'b1, ACXU_ADDR_CTRL, 32'h4);
		foreach (acc[k]) begin
			pipe.run(k == 0 ? 32'h04000e7c : k == 1 ? 32'h00000e7d : 32'h0000003c,
				32'h0, got, wb, ctl);
			chk({31'h0, got}, 32'h0);
			chk(ctl, 32'h4);
		end
		bus(1'b0, ACXU_ADDR_ISTAT, 32'h0);
		chk(q, 32'h3);
		@(negedge clock);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, ACXU_ADDR_IMASK, 32'h3);
		@(negedge clock);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, ACXU_ADDR_ISTAT, 32'h1);
		bus(1'b0, ACXU_ADDR_ISTAT, 32'h0);
		chk(q, 32'h2);
		bus(1'b1, ACXU_ADDR_ISTAT, 32'h2);
		@(negedge clock);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, ACXU_ADDR_IMASK, 32'h1);
		r = rows[15];
		pipe.run({16'h0, r.sel, r.sub, 6'h3c}, r.src, got, wb, ctl);
		@(negedge clock);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, ACXU_ADDR_IMASK, 32'h0);
		@(negedge clock);
		chk({31'h0, irq}, 32'h0);
		// a low enable stalls the issue and freezes every register
		r = rows[16];
		@(posedge clock);
		ce <= 1'b0;
		fork
			pipe.run({16'h0, r.sel, r.sub, 6'h3c}, r.src, got, wb, ctl);
			begin
				repeat (4) @(posedge clock);
				chk({30'h0, issue_ready, wb_valid}, 32'h0);
				chk(dsp_control, r.cin);
				ce <= 1'b1;
			end
		join
		chk({31'h0, got}, 32'h1);
		chk(wb.data, r.dat);
		chk(ctl, r.cex);
		// mid-run reset clears flags, status and accumulators
		@(posedge clock);
		rst_b <= 1'b0;
		@(posedge clock);
		chk(dsp_control, ACXU_CTRL_RST);
		chk({30'h0, irq, wb_valid}, 32'h0);
		rst_b <= 1'b1;
		bus(1'b0, ACXU_ADDR_ISTAT, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, ACXU_ADDR_ACC_LO, 32'h0);
		chk(q, 32'h0);
		stop_test();
	end
endmodule // tb_top

`default_nettype wire
